//--- pkg/radio_fifo_pkg.sv
package radio_fifo_pkg;
  // ----------------------------------------
  // buffer geometry
  // ----------------------------------------
  localparam int unsigned BUF_DEPTH = 64;        // bytes per buffer
  localparam int unsigned BUF_WIDTH = 8;         // byte wide
  localparam int unsigned CNT_W = 7;             // count 0..64
  localparam int unsigned STAGE_DEPTH = 32;      // link-side staging fifo
  // ----------------------------------------
  // threshold coding
  // ----------------------------------------
  localparam int unsigned THR_W = 4;             // threshold_select width
  localparam logic [6:0] RX_THR_STEP = 7'h04;    // rx threshold step
  localparam logic [6:0] TX_THR_BASE = 7'h3D;    // tx threshold at setting 0 (61)
  localparam logic [6:0] TX_THR_STEP = 7'h04;    // tx threshold step
  // ----------------------------------------
  // output pin signal select codes
  // ----------------------------------------
  localparam logic [1:0] SEL_RX_THR = 2'h0;      // rx at/above threshold
  localparam logic [1:0] SEL_TX_THR = 2'h1;      // tx at/above threshold
  localparam logic [1:0] SEL_RX_OVF = 2'h2;      // rx overflow flag
  localparam logic [1:0] SEL_TX_UNF = 2'h3;      // tx underflow flag
  // ----------------------------------------
  // status byte layout
  // ----------------------------------------
  localparam int unsigned STAT_FILL_W = 4;       // fill grade field width
  localparam int unsigned STAT_FILL_LSB = 0;     // fill grade position
endpackage

//--- core/byte_fifo.sv
`timescale 1ns/1ns
// registered-read fifo with valid/ready both sides
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clock_in,                 // system clock
  input wire logic rst_n_in,                 // synced reset, active low
  input wire logic flush_in,                 // drop all contents
  input wire logic [WIDTH-1:0] in_data_in,   // write data
  input wire logic in_valid_in,              // write request
  output logic in_ready_out,                 // not full
  output logic [WIDTH-1:0] out_data_out,     // registered read data
  output logic out_valid_out,                // out data valid
  input wire logic out_ready_in              // consumer takes data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];             // storage
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;     // pointers
  logic [AW:0] cnt_q, cnt_d;                 // stored words
  logic [WIDTH-1:0] dat_q, dat_d;            // output register
  logic ov_q, ov_d;                          // output register valid
  logic push, pop;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    in_ready_out = (cnt_q != (AW+1)'(DEPTH));
    push = in_valid_in && in_ready_out;
    // refill output register whenever empty or being taken
    pop = (cnt_q != '0) && (!ov_q || out_ready_in);
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    dat_d = pop ? mem[rp_q] : dat_q;
    ov_d = pop ? 1'b1 : (out_ready_in ? 1'b0 : ov_q);
    if (flush_in) begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
      ov_d = 1'b0;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      dat_q <= '0;
      ov_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      dat_q <= dat_d;
      ov_q <= ov_d;
    end
  end

  // storage has no reset, so memory inference stays possible
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wp_q] <= in_data_in;
    end
  end

  assign out_data_out = dat_q;
  assign out_valid_out = ov_q;
endmodule

//--- core/radio_data_fifo_pair.sv
`timescale 1ns/1ns
// What this block does
// - two separate 64-byte rx and tx buffers
// - host reads rx, writes tx via spi
// - detect rx overflow and tx underflow
// - status byte: rx fill on read, tx on write
// - byte counts readable as status fields
// - rx store plus last-byte read duplicates byte
// - one 4-bit threshold setting, 16 values
// - rx threshold 4(s+1), tx 61-4s
// - threshold flag at/above level, on pins
// - sleep empties both buffers
module radio_data_fifo_pair #(
  parameter int unsigned DEPTH = radio_fifo_pkg::BUF_DEPTH,       // bytes per buffer
  parameter int unsigned STAGE_DEPTH = radio_fifo_pkg::STAGE_DEPTH // link staging depth
) (
  input wire logic clock_in,                            // crystal clock, 100 MHz
  input wire logic resetn_in,                           // async reset, active low
  input wire logic sleep_in,                            // lowest-power sleep state
  // host side
  input wire logic host_rd_in,                          // pop one rx byte
  output logic [7:0] host_rd_data_out,                  // rx byte, registered
  input wire logic host_wr_in,                          // push one tx byte
  input wire logic [7:0] host_wr_data_in,               // tx byte
  input wire logic header_valid_in,                     // spi header shifting
  input wire logic header_is_read_in,                   // header is a read access
  output logic [7:0] status_byte_out,                   // chip status byte
  output logic [6:0] receive_byte_count_out,            // receive_count_status field
  output logic [6:0] transmit_byte_count_out,           // transmit_count_status field
  output logic rx_overflow_out,                         // sticky rx overflow
  output logic tx_underflow_out,                        // sticky tx underflow
  input wire logic clear_rx_overflow_in,                // flush rx, clear overflow
  input wire logic clear_tx_underflow_in,               // flush tx, clear underflow
  input wire logic [3:0] threshold_select_in,           // buffer_threshold_config
  input wire logic [1:0] output_pin_signal_select_in,   // pin source select
  output logic general_purpose_output_pin_out,          // selected indication
  output logic rx_threshold_out,                        // rx at/above threshold
  output logic tx_threshold_out,                        // tx at/above threshold
  // receive path (link clock domain)
  input wire logic link_clk_in,                         // bit clock from receive path
  input wire logic rx_bit_in,                           // received bit, msb first
  input wire logic rx_bit_en_in,                        // bit qualifier
  // transmit path
  input wire logic tx_take_in,                          // modulator takes a byte
  output logic [7:0] tx_byte_out,                       // byte to modulator
  output logic tx_byte_valid_out,                       // tx buffer not empty
  output logic stage_ready_out                          // staging fifo can accept
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1_q, rst_n;                                // two-stage reset sync
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // ----------------------------------------
  // link input synchronisers
  // ----------------------------------------
  logic [2:0] lk_s1_q, lk_s2_q;                         // clk, bit, enable
  logic lk_clk_prev_q;                                  // edge detect on second stage
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      lk_s1_q <= '0;
      lk_s2_q <= '0;
      lk_clk_prev_q <= 1'b0;
    end else begin
      lk_s1_q <= {link_clk_in, rx_bit_in, rx_bit_en_in};
      lk_s2_q <= lk_s1_q;
      lk_clk_prev_q <= lk_s2_q[2];
    end
  end
  logic lk_rise;                                        // one-cycle sample enable
  assign lk_rise = lk_s2_q[2] && !lk_clk_prev_q;

  // ----------------------------------------
  // bit assembler
  // ----------------------------------------
  logic [7:0] sh_q, sh_d;                               // shift register
  logic [2:0] bc_q, bc_d;                               // bits collected
  logic asm_v_q, asm_v_d;                               // byte ready for staging
  logic [7:0] asm_b_q, asm_b_d;                         // assembled byte
  logic stage_in_ready;
  always_comb begin
    sh_d = sh_q;
    bc_d = bc_q;
    asm_b_d = asm_b_q;
    asm_v_d = asm_v_q && !stage_in_ready;
    if (sleep_in) begin
      bc_d = '0;
      asm_v_d = 1'b0;
    end else if (lk_rise && lk_s2_q[0]) begin
      sh_d = {sh_q[6:0], lk_s2_q[1]};
      bc_d = bc_q + 3'd1;
      if (bc_q == 3'd7) begin
        asm_b_d = {sh_q[6:0], lk_s2_q[1]};
        asm_v_d = 1'b1;                                 // a stalled byte is overwritten
      end
    end
  end
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= '0;
      bc_q <= '0;
      asm_v_q <= 1'b0;
      asm_b_q <= '0;
    end else begin
      sh_q <= sh_d;
      bc_q <= bc_d;
      asm_v_q <= asm_v_d;
      asm_b_q <= asm_b_d;
    end
  end

  // ----------------------------------------
  // staging fifo between link and rx buffer
  // ----------------------------------------
  logic [7:0] stg_data;
  logic stg_valid, stg_ready;
  byte_fifo #(.WIDTH(8), .DEPTH(STAGE_DEPTH)) stage_fifo (
    .clock_in(clock_in),
    .rst_n_in(rst_n),
    .flush_in(sleep_in),
    .in_data_in(asm_b_q),
    .in_valid_in(asm_v_q),
    .in_ready_out(stage_in_ready),
    .out_data_out(stg_data),
    .out_valid_out(stg_valid),
    .out_ready_in(stg_ready)
  );
  assign stage_ready_out = stage_in_ready;

  // ----------------------------------------
  // the two byte buffers
  // ----------------------------------------
  logic [7:0] rx_mem [DEPTH];                           // receive buffer
  logic [7:0] tx_mem [DEPTH];                           // transmit buffer
  logic [5:0] rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d;
  logic [5:0] tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d;
  logic [6:0] rx_cnt_q, rx_cnt_d, tx_cnt_q, tx_cnt_d;
  logic rx_ovf_q, rx_ovf_d, tx_unf_q, tx_unf_d;
  logic [7:0] rd_q, rd_d;                               // host read data register
  logic rx_push, rx_pop, tx_push, tx_pop, rx_full, rx_empty, tx_empty;

  always_comb begin
    rx_full = (rx_cnt_q == 7'(DEPTH));
    rx_empty = (rx_cnt_q == '0);
    tx_empty = (tx_cnt_q == '0);
    stg_ready = 1'b1;                                   // rx buffer always drains staging
    rx_push = stg_valid && !rx_full;
    rx_pop = host_rd_in && !rx_empty;
    tx_push = host_wr_in;                               // overfill corrupts
    tx_pop = tx_take_in && !tx_empty;
    rx_wp_d = rx_push ? rx_wp_q + 6'd1 : rx_wp_q;
    tx_wp_d = tx_push ? tx_wp_q + 6'd1 : tx_wp_q;
    tx_rp_d = tx_pop ? tx_rp_q + 6'd1 : tx_rp_q;
    // simultaneous store and last-byte read: pointer holds, byte repeats
    if (rx_pop && !(rx_push && rx_cnt_q == 7'd1)) begin
      rx_rp_d = rx_rp_q + 6'd1;
    end else begin
      rx_rp_d = rx_rp_q;
    end
    rx_cnt_d = rx_cnt_q + 7'(rx_push) - 7'(rx_pop && rx_rp_d != rx_rp_q);
    tx_cnt_d = (tx_push && tx_cnt_q == 7'(DEPTH)) ? tx_cnt_q :
               tx_cnt_q + 7'(tx_push) - 7'(tx_pop);
    rd_d = rx_pop ? rx_mem[rx_rp_q] : rd_q;
    // set wins over clear
    rx_ovf_d = (stg_valid && rx_full) || (rx_ovf_q && !clear_rx_overflow_in);
    tx_unf_d = (tx_take_in && tx_empty) || (tx_unf_q && !clear_tx_underflow_in);
    if (clear_rx_overflow_in) begin
      rx_wp_d = '0;
      rx_rp_d = '0;
      rx_cnt_d = '0;
    end
    if (clear_tx_underflow_in) begin
      tx_wp_d = '0;
      tx_rp_d = '0;
      tx_cnt_d = '0;
    end
    if (sleep_in) begin
      rx_wp_d = '0;
      rx_rp_d = '0;
      rx_cnt_d = '0;
      tx_wp_d = '0;
      tx_rp_d = '0;
      tx_cnt_d = '0;
      rx_ovf_d = 1'b0;
      tx_unf_d = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_wp_q <= '0;
      rx_rp_q <= '0;
      tx_wp_q <= '0;
      tx_rp_q <= '0;
      rx_cnt_q <= '0;
      tx_cnt_q <= '0;
      rx_ovf_q <= 1'b0;
      tx_unf_q <= 1'b0;
      rd_q <= '0;
    end else begin
      rx_wp_q <= rx_wp_d;
      rx_rp_q <= rx_rp_d;
      tx_wp_q <= tx_wp_d;
      tx_rp_q <= tx_rp_d;
      rx_cnt_q <= rx_cnt_d;
      tx_cnt_q <= tx_cnt_d;
      rx_ovf_q <= rx_ovf_d;
      tx_unf_q <= tx_unf_d;
      rd_q <= rd_d;
    end
  end

  // storage, unreset
  always_ff @(posedge clock_in) begin
    if (rx_push) begin
      rx_mem[rx_wp_q] <= stg_data;
    end
    if (tx_push) begin
      tx_mem[tx_wp_q] <= host_wr_data_in;
    end
  end

  // ----------------------------------------
  // thresholds and output pin
  // ----------------------------------------
  logic [6:0] rx_thr, tx_thr;
  logic [7:0] stat_d, stat_q;
  logic gpo_d, gpo_q, rx_thr_q, tx_thr_q;
  always_comb begin
    rx_thr = radio_fifo_pkg::RX_THR_STEP * (7'(threshold_select_in) + 7'd1);
    tx_thr = radio_fifo_pkg::TX_THR_BASE - radio_fifo_pkg::TX_THR_STEP * 7'(threshold_select_in);
    // comparisons rise and fall with the count
    unique case (output_pin_signal_select_in)
      radio_fifo_pkg::SEL_RX_THR: gpo_d = (rx_cnt_d >= rx_thr);
      radio_fifo_pkg::SEL_TX_THR: gpo_d = (tx_cnt_d >= tx_thr);
      radio_fifo_pkg::SEL_RX_OVF: gpo_d = rx_ovf_d;
      radio_fifo_pkg::SEL_TX_UNF: gpo_d = tx_unf_d;
    endcase
    // fill grade saturates at 15 in a 4-bit field
    stat_d = '0;
    if (header_is_read_in) begin
      stat_d[3:0] = (rx_cnt_d > 7'd15) ? 4'hF : rx_cnt_d[3:0];
    end else begin
      stat_d[3:0] = (tx_cnt_d > 7'd15) ? 4'hF : tx_cnt_d[3:0];
    end
  end
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      stat_q <= '0;
      gpo_q <= 1'b0;
      rx_thr_q <= 1'b0;
      tx_thr_q <= 1'b0;
    end else begin
      if (header_valid_in) begin
        stat_q <= stat_d;
      end
      gpo_q <= gpo_d;
      rx_thr_q <= (rx_cnt_d >= rx_thr);
      tx_thr_q <= (tx_cnt_d >= tx_thr);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign host_rd_data_out = rd_q;
  assign status_byte_out = stat_q;
  assign receive_byte_count_out = rx_cnt_q;
  assign transmit_byte_count_out = tx_cnt_q;
  assign rx_overflow_out = rx_ovf_q;
  assign tx_underflow_out = tx_unf_q;
  assign general_purpose_output_pin_out = gpo_q;
  assign rx_threshold_out = rx_thr_q;
  assign tx_threshold_out = tx_thr_q;
  assign tx_byte_out = tx_mem[tx_rp_q];
  assign tx_byte_valid_out = !tx_empty;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // a flush in the same cycle moves the pointer, so it is left out here
  sequence last_read_with_store_s;
    rx_pop && rx_push && rx_cnt_q == 7'd1 && !sleep_in && !clear_rx_overflow_in;
  endsequence
  rx_dup_read_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    last_read_with_store_s |=> rx_rp_q == $past(rx_rp_q))
    else $error("rx pointer advanced on duplicate case");
  rx_overflow_set_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    stg_valid && rx_full && !sleep_in |=> rx_overflow_out)
    else $error("rx overflow not flagged");
  tx_underflow_set_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    tx_take_in && tx_empty && !sleep_in |=> tx_underflow_out)
    else $error("tx underflow not flagged");
  rx_count_max_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    rx_cnt_q <= 7'(DEPTH) && tx_cnt_q <= 7'(DEPTH))
    else $error("buffer count above depth");
  sleep_empty_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    sleep_in |=> receive_byte_count_out == '0 && transmit_byte_count_out == '0)
    else $error("buffers not emptied by sleep");
  rx_thr_level_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    ##1 rx_threshold_out == (rx_cnt_q >= 7'd4 * (7'($past(threshold_select_in)) + 7'd1)))
    else $error("rx threshold flag wrong");
  tx_thr_level_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    ##1 tx_threshold_out == (tx_cnt_q >= 7'd61 - 7'd4 * 7'($past(threshold_select_in))))
    else $error("tx threshold flag wrong");
  thr_fall_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    $fell(rx_threshold_out) |-> rx_cnt_q < 7'd4 * (7'($past(threshold_select_in)) + 7'd1))
    else $error("rx threshold fell while above level");
  status_fill_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    header_valid_in && header_is_read_in && rx_cnt_d < 7'd15 |=> status_byte_out[3:0] == $past(rx_cnt_d[3:0]))
    else $error("status byte does not show rx fill");
  rx_pop_count_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    rx_pop && !rx_push && rx_cnt_q > 7'd1 && !sleep_in && !clear_rx_overflow_in
    |=> receive_byte_count_out == $past(rx_cnt_q) - 7'd1)
    else $error("rx count not decremented");
endmodule

//--- tb/link_bit_source.sv
`timescale 1ns/1ns
// serial receive-path model: msb first, clock still between frames
module link_bit_source (
  output logic link_clk_out,  // bit clock, idle low
  output logic rx_bit_out,    // serial data
  output logic rx_bit_en_out  // bit qualifier
);
  initial begin
    link_clk_out = 1'b0;
    rx_bit_out = 1'b0;
    rx_bit_en_out = 1'b0;
  end
  // ----------------------------------------
  // one byte frame, 125 ns bit period
  // ----------------------------------------
  task automatic send_byte(input logic [7:0] b);
    #2;  // keep link edges off the system clock edges
    for (int i = 7; i >= 0; i--) begin
      rx_bit_out = b[i];  // data moves while clock is low
      rx_bit_en_out = 1'b1;
      #62 link_clk_out = 1'b1;
      #63 link_clk_out = 1'b0;
    end
    // released line shows the inverse, never a stale copy
    rx_bit_en_out = 1'b0;
    rx_bit_out = ~b[0];
    #8;  // idle gap keeps every frame on the 10 ns grid
  endtask
endmodule

//--- tb/radio_data_fifo_pair_tb.sv
`timescale 1ns/1ns
module radio_data_fifo_pair_tb;
  logic clock_in = 1'b0;  // 100 MHz
  logic resetn_in, sleep_in, host_rd_in, host_wr_in, header_valid_in, header_is_read_in;
  logic clear_rx_overflow_in, clear_tx_underflow_in, tx_take_in;
  logic [7:0] host_wr_data_in, host_rd_data_out, status_byte_out, tx_byte_out;
  logic [3:0] threshold_select_in;
  logic [1:0] output_pin_signal_select_in;
  logic [6:0] receive_byte_count_out, transmit_byte_count_out;
  logic rx_overflow_out, tx_underflow_out, general_purpose_output_pin_out;
  logic rx_threshold_out, tx_threshold_out, tx_byte_valid_out, stage_ready_out;
  logic link_clk_in, rx_bit_in, rx_bit_en_in;
  int n_errors = 0;
  int check_count = 0;

  always #5 clock_in = ~clock_in;

  radio_data_fifo_pair uut (.clock_in, .resetn_in, .sleep_in, .host_rd_in, .host_rd_data_out,
    .host_wr_in, .host_wr_data_in, .header_valid_in, .header_is_read_in, .status_byte_out,
    .receive_byte_count_out, .transmit_byte_count_out, .rx_overflow_out, .tx_underflow_out,
    .clear_rx_overflow_in, .clear_tx_underflow_in, .threshold_select_in,
    .output_pin_signal_select_in, .general_purpose_output_pin_out, .rx_threshold_out,
    .tx_threshold_out, .link_clk_in, .rx_bit_in, .rx_bit_en_in, .tx_take_in, .tx_byte_out,
    .tx_byte_valid_out, .stage_ready_out);

  link_bit_source src (.link_clk_out(link_clk_in), .rx_bit_out(rx_bit_in), .rx_bit_en_out(rx_bit_en_in));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] d(input int i);
    return 8'(i * 7 + 3);
  endfunction
  function automatic logic [7:0] e(input int i);
    return 8'(i * 13 + 1);
  endfunction
  task automatic wrap_up();
    if (n_errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  // one-cycle pulse, then one settling cycle
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    step(1);
    sig = 1'b0;
    step(1);
  endtask
  task automatic hdr(input logic rd);
    header_is_read_in = rd;
    pulse(header_valid_in);
  endtask
  // bounded poll of the receive count, far faster than bytes arrive
  task automatic wait_rx(input logic [6:0] n);
    int k;
    for (k = 0; k < 300 && receive_byte_count_out !== n; k++) step(1);
    if (k == 300) begin
      n_errors++;
      wrap_up();
    end
  endtask
  task automatic thr_table(input int rc, input int tc);
    for (int s = 0; s < 16; s++) begin
      threshold_select_in = 4'(s);
      step(2);
      chk(rx_threshold_out, rc >= 4 * (s + 1));
      chk(tx_threshold_out, tc >= 61 - 4 * s);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(stage_ready_out, 8'h01);
    chk(receive_byte_count_out, 0);
    chk(transmit_byte_count_out, 0);
    chk(rx_overflow_out, 0);
    chk(tx_underflow_out, 0);
    chk(tx_byte_valid_out, 0);
  endtask
  task automatic t_tx();
    threshold_select_in = 4'd13;
    output_pin_signal_select_in = 2'd1;
    step(2);
    // fill to exactly 64, never beyond
    for (int i = 1; i <= 64; i++) begin
      host_wr_data_in = d(i - 1);
      pulse(host_wr_in);
      chk(transmit_byte_count_out, 8'(i));
      chk(tx_threshold_out, i >= 9);
      chk(general_purpose_output_pin_out, i >= 9);
    end
    hdr(1'b0);
    chk(status_byte_out, 8'h0F);
    for (int i = 0; i < 64; i++) begin
      chk(tx_byte_out, d(i));
      pulse(tx_take_in);
      chk(transmit_byte_count_out, 8'(63 - i));
      chk(tx_threshold_out, (63 - i) >= 9);
      if (i == 30) begin
        thr_table(0, 33);
        threshold_select_in = 4'd13;
        step(2);
      end
    end
    chk(tx_byte_valid_out, 0);
    hdr(1'b0);
    chk(status_byte_out, 8'h00);
    pulse(tx_take_in);
    chk(tx_underflow_out, 1);
    output_pin_signal_select_in = 2'd3;
    step(2);
    chk(general_purpose_output_pin_out, 1);
    pulse(clear_tx_underflow_in);
    step(1);
    chk(tx_underflow_out, 0);
    chk(general_purpose_output_pin_out, 0);
  endtask
  task automatic t_rx();
    threshold_select_in = 4'd0;
    output_pin_signal_select_in = 2'd0;
    // whole short packet lands before any read
    for (int k = 0; k < 5; k++) src.send_byte(e(k));
    wait_rx(7'd5);
    step(2);
    chk(rx_threshold_out, 1);
    chk(general_purpose_output_pin_out, 1);
    hdr(1'b1);
    chk(status_byte_out, 8'h05);
    // reads stop at empty
    for (int k = 0; k < 5; k++) begin
      pulse(host_rd_in);
      chk(host_rd_data_out, e(k));
      chk(receive_byte_count_out, 8'(4 - k));
      chk(rx_threshold_out, (4 - k) >= 4);
    end
  endtask
  task automatic t_ovf();
    threshold_select_in = 4'd15;
    output_pin_signal_select_in = 2'd2;
    for (int k = 0; k < 65; k++) src.send_byte(e(k));
    wait_rx(7'd64);
    step(20);
    chk(receive_byte_count_out, 8'd64);
    chk(rx_overflow_out, 1);
    chk(stage_ready_out, 8'h01);
    chk(rx_threshold_out, 1);
    chk(general_purpose_output_pin_out, 1);
    hdr(1'b1);
    chk(status_byte_out, 8'h0F);
    pulse(host_rd_in);
    chk(host_rd_data_out, e(0));
    pulse(clear_rx_overflow_in);
    step(1);
    chk(receive_byte_count_out, 0);
    chk(rx_overflow_out, 0);
  endtask
  task automatic t_sleep();
    host_wr_data_in = 8'hA5;
    pulse(host_wr_in);
    src.send_byte(8'h3C);
    wait_rx(7'd1);
    sleep_in = 1'b1;
    step(3);
    sleep_in = 1'b0;
    step(2);
    chk(receive_byte_count_out, 0);
    chk(transmit_byte_count_out, 0);
    chk(tx_byte_valid_out, 0);
  endtask
  // a byte lands as the last one is read: the last one comes out twice
  task automatic t_dup();
    int k;
    src.send_byte(8'h5A);
    wait_rx(7'd1);
    fork
      src.send_byte(8'hC3);
    join_none
    // staged byte shown at this negedge enters the buffer at the next edge
    for (k = 0; k < 300 && uut.stg_valid !== 1'b1; k++) step(1);
    if (k == 300) begin
      n_errors++;
      wrap_up();
    end
    pulse(host_rd_in);
    chk(host_rd_data_out, 8'h5A);
    chk(receive_byte_count_out, 8'h02);
    pulse(host_rd_in);
    chk(host_rd_data_out, 8'h5A);
    pulse(host_rd_in);
    chk(host_rd_data_out, 8'hC3);
    chk(receive_byte_count_out, 8'h00);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {resetn_in, sleep_in, host_rd_in, host_wr_in, header_valid_in, header_is_read_in} = '0;
    {clear_rx_overflow_in, clear_tx_underflow_in, tx_take_in} = '0;
    host_wr_data_in = 8'h00;
    threshold_select_in = 4'h0;
    output_pin_signal_select_in = 2'h0;
    step(5);
    resetn_in = 1'b1;
    step(4);
    t_reset();
    t_tx();
    t_rx();
    t_ovf();
    t_sleep();
    t_dup();
    wrap_up();
  end
endmodule
